// ### design/clockgen_consts.svh
// Offsets, field positions, reset values and counts of the clock generator config bank.
// Included by the bank module only; definitions only.
`ifndef CLOCKGEN_CONSTS_SVH
`define CLOCKGEN_CONSTS_SVH

`define OFS_OUTPUT_ENABLE   8'h00
`define OFS_SPREAD_AMP      8'h01
`define OFS_DIFF_SLEW       8'h02
`define OFS_REF_CTRL        8'h03
`define OFS_RESERVED4       8'h04
`define OFS_REV_MAKER       8'h05
`define OFS_PART_ID         8'h06
`define OFS_READBACK_LEN    8'h07

`define SPREAD_STRAP_MSB    7
`define SPREAD_STRAP_LSB    6
`define SPREAD_OVR_BIT      5
`define SPREAD_SW_MSB       4
`define SPREAD_SW_LSB       3
`define AMP_RSVD_BIT        2
`define REF_WOL_BIT         5
`define REF_OE_BIT          4

`define RST_DIFF_OE         6'h3f
`define RST_SLEW            6'h3f
`define RST_AMP             2'h2
`define RST_REF_SLEW        2'h1
`define RST_READBACK_LEN    5'h08
`define REF_RSVD_ONES       8'h0d
`define UNMAPPED_BYTE       8'hff
`define SPREAD_OFF          2'h0
`define SPREAD_DOWN_HALF    2'h3

`endif

// ### design/clockgen_pkg.sv
// Types shared by the clock generator configuration bank.
// Constants live in clockgen_consts.svh.
package clockgen_pkg;

  // Link transaction phase
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_INDEX = 6'h04,
    ST_COUNT = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } phase_t;

  // Software-writable configuration
  typedef struct packed {
    logic [5:0] diff_oe;
    logic       spread_ovr;
    logic [1:0] spread_sw;
    logic [1:0] amp;
    logic [5:0] slew;
    logic [1:0] ref_slew;
    logic       ref_wol;
    logic       ref_oe;
    logic [4:0] rb_len;
  } cfg_t;

endpackage

// ### design/clockgen_smbus_config_regs.sv
// Configuration and identification byte bank of a spread-spectrum clock generator.
// Assumes a bit-level two-wire front end that delivers start, stop and whole bytes,
// and asks for each byte to be returned; every input but the asynchronous rst_i is synchronous to sys_clk_i.
`timescale 1ns/100ps
`include "clockgen_consts.svh"

module clockgen_smbus_config_regs #(
  parameter logic [6:0] DEV_ADDR  = 7'h50,  // Arbitrary bus address
  parameter logic [3:0] REV_ID    = 4'h0,   // Arbitrary revision value
  parameter logic [3:0] MAKER_ID  = 4'h0,   // Arbitrary maker value
  parameter logic [7:0] PART_ID   = 8'h00,  // Arbitrary part type and id
  parameter int         N_OUT     = 6
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [1:0]       spread_strap_i,
  input  wire logic [N_OUT-1:0] diff_oe_n_i,
  input  wire logic             power_down_i,
  input  wire logic             bus_start_i,
  input  wire logic             bus_stop_i,
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_byte_i,
  input  wire logic             tx_req_i,
  output logic                  ack_valid_o,
  output logic                  ack_o,
  output logic                  tx_valid_o,
  output logic [7:0]            tx_byte_o,
  output logic [N_OUT-1:0]      diff_run_o,
  output logic [N_OUT-1:0]      diff_slew_fast_o,
  output logic [1:0]            amplitude_o,
  output logic [1:0]            spread_mode_o,
  output logic [1:0]            ref_slew_o,
  output logic                  ref_run_o
);

  // Spread bit positions 7,6,4,3,2,0 onto outputs 5..0
  function automatic logic [7:0] spread6(input logic [5:0] v);
    spread6 = {v[5], v[4], 1'b0, v[3], v[2], v[1], 1'b0, v[0]};
  endfunction
  function automatic logic [5:0] pack6(input logic [7:0] b);
    pack6 = {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction
  clockgen_pkg::cfg_t   cfg_q, cfg_d;
  clockgen_pkg::phase_t phase_q, phase_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] cnt_q, cnt_d;
  logic       first_q, first_d;
  logic [1:0] strap_q, strap_d;
  logic       strap_ok_q;
  logic       ack_valid_d, ack_d, tx_valid_d;
  logic [7:0] tx_byte_d;

  // Read view of every byte; reserved bits fixed
  function automatic logic [7:0] reg_read(input logic [7:0] a, input clockgen_pkg::cfg_t c,
                                          input logic [1:0] s);
    case (a)
      `OFS_OUTPUT_ENABLE: reg_read = spread6(c.diff_oe);
      `OFS_SPREAD_AMP:    reg_read = {s, c.spread_ovr, c.spread_sw, 1'b1, c.amp};
      `OFS_DIFF_SLEW:     reg_read = spread6(c.slew);
      `OFS_REF_CTRL:      reg_read = {c.ref_slew, c.ref_wol, c.ref_oe, 4'h0} | `REF_RSVD_ONES;
      `OFS_RESERVED4:     reg_read = 8'h00;
      `OFS_REV_MAKER:     reg_read = {REV_ID, MAKER_ID};
      `OFS_PART_ID:       reg_read = PART_ID;
      `OFS_READBACK_LEN:  reg_read = {3'h0, c.rb_len};
      default:            reg_read = `UNMAPPED_BYTE;
    endcase
  endfunction

  // Strap catch once after reset release
  // latch strap level
  always_comb
  begin
    strap_d = strap_ok_q ? strap_q : spread_strap_i;
  end
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_q    <= 2'h0;
      strap_ok_q <= 1'b0;
    end
    else
    begin
      strap_q    <= strap_d;
      strap_ok_q <= 1'b1;
    end
  end

  // Transaction sequencing and register writes
  always_comb
  begin
    phase_d     = phase_q;
    cfg_d       = cfg_q;
    idx_d       = idx_q;
    cnt_d       = cnt_q;
    first_d     = first_q;
    ack_valid_d = 1'b0;
    ack_d       = 1'b0;
    tx_valid_d  = 1'b0;
    tx_byte_d   = tx_byte_o;
    if (bus_stop_i)
      phase_d = clockgen_pkg::ST_IDLE;
    else if (bus_start_i)
      phase_d = clockgen_pkg::ST_ADDR;
    else
    begin
      case (phase_q)
        clockgen_pkg::ST_IDLE:
          phase_d = clockgen_pkg::ST_IDLE;
        clockgen_pkg::ST_ADDR:
          if (rx_valid_i)
          begin
            ack_valid_d = 1'b1;
            ack_d       = (rx_byte_i[7:1] == DEV_ADDR);
            first_d     = 1'b1;
            if (rx_byte_i[7:1] != DEV_ADDR)
              phase_d = clockgen_pkg::ST_IDLE;
            else if (rx_byte_i[0])
              phase_d = clockgen_pkg::ST_RDATA;
            else
              phase_d = clockgen_pkg::ST_INDEX;
          end
        clockgen_pkg::ST_INDEX:
          if (rx_valid_i)
          begin
            ack_valid_d = 1'b1;
            ack_d       = 1'b1;
            idx_d       = rx_byte_i;
            phase_d     = clockgen_pkg::ST_COUNT;
          end
        clockgen_pkg::ST_COUNT:
          if (rx_valid_i)
          begin
            ack_valid_d = 1'b1;
            ack_d       = 1'b1;
            cnt_d       = rx_byte_i;
            phase_d     = clockgen_pkg::ST_WDATA;
          end
        clockgen_pkg::ST_WDATA:
          if (rx_valid_i)
          begin
            ack_valid_d = 1'b1;
            ack_d       = (cnt_q != 8'h00);
            if (cnt_q != 8'h00)
            begin
              cnt_d = cnt_q - 8'h01;
              idx_d = idx_q + 8'h01;
              case (idx_q)
                `OFS_OUTPUT_ENABLE: cfg_d.diff_oe = pack6(rx_byte_i);
                `OFS_SPREAD_AMP:
                begin
                  cfg_d.spread_ovr = rx_byte_i[`SPREAD_OVR_BIT];
                  cfg_d.amp        = rx_byte_i[1:0];
                  // select bits follow only with override set
                  if (rx_byte_i[`SPREAD_OVR_BIT])
                    cfg_d.spread_sw = rx_byte_i[`SPREAD_SW_MSB:`SPREAD_SW_LSB];
                end
                `OFS_DIFF_SLEW: cfg_d.slew = pack6(rx_byte_i);
                `OFS_REF_CTRL:
                begin
                  cfg_d.ref_slew = rx_byte_i[7:6];
                  cfg_d.ref_wol  = rx_byte_i[`REF_WOL_BIT];
                  cfg_d.ref_oe   = rx_byte_i[`REF_OE_BIT];
                end
                `OFS_READBACK_LEN: cfg_d.rb_len = rx_byte_i[4:0];
                default: cfg_d = cfg_q;
              endcase
            end
          end
        // count byte first, then data from index
        clockgen_pkg::ST_RDATA:
          if (tx_req_i)
          begin
            tx_valid_d = 1'b1;
            first_d    = 1'b0;
            if (first_q)
              tx_byte_d = {3'h0, cfg_q.rb_len};
            else
            begin
              tx_byte_d = reg_read(idx_q, cfg_q, strap_q);
              idx_d     = idx_q + 8'h01;
            end
          end
        default:
          phase_d = clockgen_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_q     <= clockgen_pkg::ST_IDLE;
      cfg_q       <= '{diff_oe: `RST_DIFF_OE, spread_ovr: 1'b0, spread_sw: 2'h0, amp: `RST_AMP,
                       slew: `RST_SLEW, ref_slew: `RST_REF_SLEW, ref_wol: 1'b0, ref_oe: 1'b1,
                       rb_len: `RST_READBACK_LEN};
      idx_q       <= 8'h00;
      cnt_q       <= 8'h00;
      first_q     <= 1'b0;
      ack_valid_o <= 1'b0;
      ack_o       <= 1'b0;
      tx_valid_o  <= 1'b0;
      tx_byte_o   <= 8'h00;
    end
    else
    begin
      phase_q     <= phase_d;
      cfg_q       <= cfg_d;
      idx_q       <= idx_d;
      cnt_q       <= cnt_d;
      first_q     <= first_d;
      ack_valid_o <= ack_valid_d;
      ack_o       <= ack_d;
      tx_valid_o  <= tx_valid_d;
      tx_byte_o   <= tx_byte_d;
    end
  end

  // Controls driven out to the analog side
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      diff_run_o       <= '0;
      diff_slew_fast_o <= '1;
      amplitude_o      <= `RST_AMP;
      spread_mode_o    <= `SPREAD_OFF;
      ref_slew_o       <= `RST_REF_SLEW;
      ref_run_o        <= 1'b0;
    end
    else
    begin
      diff_run_o       <= cfg_q.diff_oe & ~diff_oe_n_i;
      diff_slew_fast_o <= cfg_q.slew;
      amplitude_o      <= cfg_q.amp;
      spread_mode_o    <= cfg_q.spread_ovr ? cfg_q.spread_sw : strap_q;
      ref_slew_o       <= cfg_q.ref_slew;
      // run in power down only with wake bit
      ref_run_o        <= cfg_q.ref_oe & (~power_down_i | cfg_q.ref_wol);
    end
  end

  strap_readback_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(strap_ok_q) |-> strap_q == $past(spread_strap_i) &&
    (reg_read(`OFS_SPREAD_AMP, cfg_q, strap_q) >> `SPREAD_STRAP_LSB) == {6'h00, $past(spread_strap_i)})
    else $error("strap readback differs from latched strap");
  spread_source_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 spread_mode_o == ($past(cfg_q.spread_ovr) ? $past(cfg_q.spread_sw) : $past(strap_q)))
    else $error("spread source wrong");
  sw_write_drop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (phase_q == clockgen_pkg::ST_WDATA && rx_valid_i && !bus_start_i && !bus_stop_i &&
     idx_q == `OFS_SPREAD_AMP && !rx_byte_i[`SPREAD_OVR_BIT]) |=> $stable(cfg_q.spread_sw))
    else $error("software spread select changed without override");
  spread_half_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_q.spread_ovr && cfg_q.spread_sw == `SPREAD_DOWN_HALF) |=> spread_mode_o == `SPREAD_DOWN_HALF)
    else $error("half percent spread not applied");
  slew_follow_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 diff_slew_fast_o == $past(cfg_q.slew))
    else $error("slew output not following register");
  ref_power_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (power_down_i && !cfg_q.ref_wol) |=> !ref_run_o)
    else $error("reference runs in power down without wake bit");
  count_first_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (phase_q == clockgen_pkg::ST_RDATA && first_q && tx_req_i && !bus_start_i && !bus_stop_i)
    |=> tx_valid_o && tx_byte_o == {3'h0, $past(cfg_q.rb_len)})
    else $error("block read did not open with byte count");
  data_ack_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (phase_q inside {clockgen_pkg::ST_INDEX, clockgen_pkg::ST_COUNT} && rx_valid_i &&
     !bus_start_i && !bus_stop_i) |=> ack_valid_o && ack_o)
    else $error("index or count byte not acknowledged");
  oe_override_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_q.diff_oe != 6'h3f) |=> (diff_run_o & ~$past(cfg_q.diff_oe)) == 6'h00)
    else $error("disabled output pair still running");
  reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_read(`OFS_READBACK_LEN, cfg_q, strap_q) & 8'he0) == 8'h00 &&
    (reg_read(`OFS_SPREAD_AMP, cfg_q, strap_q) & (8'h01 << `AMP_RSVD_BIT)) != 8'h00)
    else $error("reserved bits lost fixed value");
endmodule // clockgen_smbus_config_regs

// ### tb/clockgen_smbus_config_regs_bench.sv
// Self-checking bench of the clock generator config bank.
// The host model drives the link; a watcher pops expected acks and bytes on each answer.
`timescale 1ns/100ps

`define CHECK(a, e, m) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("BAD %0t %s", $time, m); \
    end \
  end

module clockgen_smbus_config_regs_bench;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  strap = 2'h0;
  logic [5:0]  oe_n = 6'h00;
  logic        pd = 1'b0;
  logic        bus_start, bus_stop, rx_valid, tx_req, ack_valid, ack, tx_valid, ref_run;
  logic [7:0]  rx_byte, tx_byte, v, w;
  logic [5:0]  diff_run, slew_fast;
  logic [1:0]  amp, spread_mode, ref_slew;
  logic [1:0]  codes[3] = '{2'h0, 2'h1, 2'h3};
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          seed = 96;

  always #12.5 sys_clk_i = ~sys_clk_i;

  smbus_host_model host_u (.sys_clk_i(sys_clk_i), .bus_start_o(bus_start), .bus_stop_o(bus_stop),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_req_o(tx_req));

  clockgen_smbus_config_regs #(.REV_ID(4'h3), .MAKER_ID(4'h9), .PART_ID(8'h5a)) dut_u (  // Arbitrary ids
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spread_strap_i(strap), .diff_oe_n_i(oe_n),
    .power_down_i(pd), .bus_start_i(bus_start), .bus_stop_i(bus_stop), .rx_valid_i(rx_valid),
    .rx_byte_i(rx_byte), .tx_req_i(tx_req), .ack_valid_o(ack_valid), .ack_o(ack),
    .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .diff_run_o(diff_run), .diff_slew_fast_o(slew_fast),
    .amplitude_o(amp), .spread_mode_o(spread_mode), .ref_slew_o(ref_slew), .ref_run_o(ref_run));

  // Six output bits sit at byte bits 7,6,4,3,2,0
  function automatic logic [5:0] map6(input logic [7:0] b);
    return {b[7:6], b[4:2], b[0]};
  endfunction

  task automatic note(input logic [7:0] b);
    host_u.tx_q.push_back(b);
  endtask

  // Notes a whole list of expected read bytes
  task automatic notes(input logic [7:0] l[$]);
    foreach (l[i])
      note(l[i]);
  endtask

  task automatic do_reset(input logic [1:0] s);
    rst_i = 1'b1;
    strap = s;
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask

  task automatic final_report();
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watcher: each answer takes the oldest note
  always @(negedge sys_clk_i)
  begin
    if (ack_valid === 1'b1)
      `CHECK(ack, host_u.ack_q.size() ? host_u.ack_q.pop_front() : 1'bx, "ack")
    if (tx_valid === 1'b1)
      `CHECK(tx_byte, host_u.tx_q.size() ? host_u.tx_q.pop_front() : 8'hxx, "read byte")
  end

  // Cut a hang short
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    foreach (codes[i])
    begin
      do_reset(codes[i]);
      note(8'h08);
      note({codes[i], 6'h06});
      host_u.read_block(8'h01, 2);
    end
    // Defaults of ref, reserved byte, ids and count, unmapped tail
    notes('{8'h08, 8'h5d, 8'h00, 8'h39, 8'h5a, 8'h08, 8'hff});
    host_u.read_block(8'h03, 7);
    // Last reset latched a high strap, so spread follows it
    `CHECK({slew_fast, amp, spread_mode, ref_slew, ref_run}, {6'h3f, 2'h2, 2'h3, 2'h1, 1'b1}, "defaults")
    for (int s = 0; s < 4; s++)
    begin
      v = 8'($random(seed));
      host_u.write_block(8'h01, 8'h01, '{{v[7:6], 1'b0, 2'(s), v[2:0]}});
      repeat (2) @(negedge sys_clk_i);
      `CHECK(spread_mode, 2'h3, "spread without override")
      host_u.write_block(8'h01, 8'h01, '{{v[7:6], 1'b1, 2'(s), v[2:0]}});
      repeat (2) @(negedge sys_clk_i);
      `CHECK(spread_mode, 2'(s), "spread with override")
      `CHECK(amp, v[1:0], "amplitude")
      note(8'h08);
      note({2'h3, 1'b1, 2'(s), 1'b1, v[1:0]});
      host_u.read_block(8'h01, 2);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      oe_n = 6'($random(seed));
      pd = 1'($random(seed));
      host_u.write_block(8'h00, 8'h01, '{v});
      host_u.write_block(8'h02, 8'h02, '{w, v, 8'h5a});
      repeat (2) @(negedge sys_clk_i);
      `CHECK(diff_run, map6(v) & ~oe_n, "pair run")
      `CHECK(slew_fast, map6(w), "slew")
      `CHECK({ref_slew, ref_run}, {v[7:6], v[4] & (~pd | v[5])}, "reference run")
      note(8'h08);
      note({v[7:4], 4'hd});
      note(8'h00);
      host_u.read_block(8'h03, 3);
    end
    host_u.write_block(8'h05, 8'h03, '{8'h00, 8'h00, 8'hff});
    notes('{8'h1f, 8'h39, 8'h5a, 8'h1f});
    host_u.read_block(8'h05, 4);
    host_u.cond(1'b0);
    host_u.send({7'h51, 1'b0}, 1'b0);
    host_u.cond(1'b1);
    repeat (4) @(negedge sys_clk_i);
    `CHECK(host_u.tx_q.size() + host_u.ack_q.size(), 0, "missing answers")
    final_report();
  end
endmodule // clockgen_smbus_config_regs_bench

// ### tb/smbus_host_model.sv
// Byte-level host on the link side of the clock generator config bank.
// Drives the link inputs just after the falling edge and notes expected acks; the bench notes expected bytes.
`timescale 1ns/100ps

module smbus_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic       sys_clk_i,
  output logic            bus_start_o,
  output logic            bus_stop_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o,
  output logic            tx_req_o
);
  logic       ack_q[$];  // Expected ack per sent byte
  logic [7:0] tx_q[$];   // Expected bytes of a read

  // Idle link at time zero
  initial
  begin
    bus_start_o = 1'b0;
    bus_stop_o  = 1'b0;
    rx_valid_o  = 1'b0;
    rx_byte_o   = 8'h00;
    tx_req_o    = 1'b0;
  end

  // One-cycle start or stop condition
  task automatic cond(input logic stop);
    @(negedge sys_clk_i);
    bus_start_o = ~stop;
    bus_stop_o  = stop;
    @(negedge sys_clk_i);
    bus_start_o = 1'b0;
    bus_stop_o  = 1'b0;
  endtask

  // One byte; data turns over once no longer valid
  task automatic send(input logic [7:0] b, input logic ack);
    @(negedge sys_clk_i);
    rx_valid_o = 1'b1;
    rx_byte_o  = b;
    ack_q.push_back(ack);
    @(negedge sys_clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o  = ~b;
  endtask

  task automatic write_block(input logic [7:0] idx, input logic [7:0] cnt, input logic [7:0] d[$]);
    cond(1'b0);
    send({DEV_ADDR, 1'b0}, 1'b1);
    send(idx, 1'b1);
    send(cnt, 1'b1);
    foreach (d[i])
      send(d[i], i < cnt);
    cond(1'b1);
  endtask

  task automatic read_block(input logic [7:0] idx, input int n);
    cond(1'b0);
    send({DEV_ADDR, 1'b0}, 1'b1);
    send(idx, 1'b1);
    cond(1'b0);
    send({DEV_ADDR, 1'b1}, 1'b1);
    repeat (n)
    begin
      @(negedge sys_clk_i);
      tx_req_o = 1'b1;
      @(negedge sys_clk_i);
      tx_req_o = 1'b0;
    end
    repeat (2) @(negedge sys_clk_i);
    cond(1'b1);
  endtask
endmodule // smbus_host_model
